// [core/pio_consts.vh]
// constants for the port 1..3 logic block
// Summary of operation
// - port one never drives pins digitally
// - port one latch resets to all ones
// - zero bit makes pin readable digital input
// - port two one bit: weak pull-up
// - port two zero bit drives low
// - external data access puts address on port two
// - modulator outputs override port two bits five, six outside external data access
// - port two bit seven feeds modulator clock
// - port two carries serial and timer functions
// - port three quasi-bidirectional like port two
// - port three alternate only when latch one
// - port three carries uart, interrupts, timers, strobes
// - read-modify-write reads the latch
// - bit operations rewrite whole latch byte
// - plain reads return sampled pin levels
// - enabled peripheral takes port two pin from general use, port three pin only when latch one
`ifndef PIO_CONSTS_VH
`define PIO_CONSTS_VH
`define PIO_ADDR_P1     8'h90
`define PIO_ADDR_P2     8'ha0
`define PIO_ADDR_P3     8'hb0
`define PIO_LATCH_RESET 8'hff
`define PIO_ZERO8       8'h00
`define PIO_BIT_SCLK    3'h0
`define PIO_BIT_MOSI    3'h1
`define PIO_BIT_MISO    3'h2
`define PIO_BIT_SS      3'h3
`define PIO_BIT_THIRD_TIMER_EXT_CONTROL    3'h4
`define PIO_BIT_MODA    3'h5
`define PIO_BIT_MODB    3'h6
`define PIO_BIT_MODCLK  3'h7
`define PIO_BIT_RXD     3'h0
`define PIO_BIT_TXD     3'h1
`define PIO_BIT_INTA    3'h2
`define PIO_BIT_INTB    3'h3
`define PIO_BIT_TCA     3'h4
`define PIO_BIT_TCB     3'h5
`define PIO_BIT_WR      3'h6
`define PIO_BIT_RD      3'h7
`define PIO_OP_WBYTE    2'h0
`define PIO_OP_WBIT     2'h1
`endif

// [core/pio_ports.v]
// port 1..3 latches, pin drivers and alternate-function routing
`timescale 1ns/100ps
`include "pio_consts.vh"
module pio_ports (
   // clock and control
   input  wire       core_clk,
   input  wire       reset,
   input  wire       clk_en,
   // special-function-register access
   input  wire [7:0] sfr_addr,
   input  wire       sfr_wr,
   input  wire [1:0] sfr_wr_op,
   input  wire [2:0] sfr_bit_sel,
   input  wire       sfr_bit_val,
   input  wire [7:0] sfr_wdata,
   input  wire       sfr_rd,
   input  wire       sfr_rd_latch,
   output reg  [7:0] sfr_rdata,
   // port one pins (input only)
   input  wire [7:0] p1_pin_in,
   output reg  [7:0] p1_analog_sel,
   // port two pins
   input  wire [7:0] p2_pin_in,
   output reg  [7:0] p2_pin_out,
   output reg  [7:0] p2_pin_oe,
   output reg  [7:0] p2_pullup_en,
   // port three pins
   input  wire [7:0] p3_pin_in,
   output reg  [7:0] p3_pin_out,
   output reg  [7:0] p3_pin_oe,
   output reg  [7:0] p3_pullup_en,
   // external data memory
   input  wire       xdata_active,
   input  wire [15:0] xdata_addr_hi,
   input  wire       xdata_wr_n,
   input  wire       xdata_rd_n,
   // peripheral enables and outputs
   input  wire       spi_en,
   input  wire       spi_master,
   input  wire       spi_sclk_out,
   input  wire       spi_mosi_out,
   input  wire       spi_miso_out,
   input  wire       modulator_en,
   input  wire       modulator_output_a,
   input  wire       modulator_output_b,
   input  wire       uart_en,
   input  wire       uart_txd_out,
   input  wire       uart_rxd_out,
   input  wire       uart_rxd_oe,
   // peripheral inputs taken from pins
   output reg        serial_periph_clock,
   output reg        spi_mosi_in,
   output reg        spi_miso_in,
   output reg        spi_ss_in,
   output reg        third_timer_clock_in,
   output reg        third_timer_ext_control,
   output reg        modulator_alt_clock_in,
   output reg        uart_rxd_in,
   output reg        ext_interrupt_a,
   output reg        ext_interrupt_b,
   output reg        timer_a_count_in,
   output reg        timer_b_count_in
);

   reg  [7:0] input_port_one_latch;
   reg  [7:0] quasi_port_two_latch;
   reg  [7:0] quasi_port_three_latch;
   reg  [7:0] p1_sample;
   reg  [7:0] p2_sample;
   reg  [7:0] p3_sample;
   reg  [7:0] next_p2_drive;
   reg  [7:0] next_p2_alt;
   reg  [7:0] next_p3_alt;
   reg  [7:0] next_p3_drive;
   reg  [7:0] next_rdata;

   // byte or single-bit update of a latch; bit ops merge into the held byte
   function [7:0] pio_merge;
      input [7:0] old;
      input [1:0] op;
      input [2:0] sel;
      input       val;
      input [7:0] wdata;
      reg   [7:0] tmp;
      begin
         tmp = old;
         if (op == `PIO_OP_WBIT) begin
            tmp[sel] = val;
         end else begin
            tmp = wdata;
         end
         pio_merge = tmp;
      end
   endfunction

   // pin driver: low when drive bit is 0, else pulled up or driven high
   function [7:0] pio_low_oe;
      input [7:0] drive;
      input [7:0] push;
      begin
         pio_low_oe = ~drive | push;
      end
   endfunction

   always @(posedge core_clk) begin
      if (reset) begin
         input_port_one_latch   <= `PIO_LATCH_RESET;
         quasi_port_two_latch   <= `PIO_LATCH_RESET;
         quasi_port_three_latch <= `PIO_LATCH_RESET;
      end else if (clk_en && sfr_wr) begin
         // latches change only on software writes, never on overrides
         case (sfr_addr)
            `PIO_ADDR_P1: begin
               input_port_one_latch <= pio_merge(input_port_one_latch, sfr_wr_op,
                                                 sfr_bit_sel, sfr_bit_val, sfr_wdata);
            end
            `PIO_ADDR_P2: begin
               quasi_port_two_latch <= pio_merge(quasi_port_two_latch, sfr_wr_op,
                                                 sfr_bit_sel, sfr_bit_val, sfr_wdata);
            end
            `PIO_ADDR_P3: begin
               quasi_port_three_latch <= pio_merge(quasi_port_three_latch, sfr_wr_op,
                                                   sfr_bit_sel, sfr_bit_val, sfr_wdata);
            end
            default: begin
            end
         endcase
      end
   end

   // pin samples; digital port one input only where latch is 0
   always @(posedge core_clk) begin
      if (reset) begin
         p1_sample <= `PIO_ZERO8;
         p2_sample <= `PIO_ZERO8;
         p3_sample <= `PIO_ZERO8;
      end else if (clk_en) begin
         p1_sample <= p1_pin_in & ~input_port_one_latch;
         p2_sample <= p2_pin_in;
         p3_sample <= p3_pin_in;
      end
   end

   always @* begin
      // port two: address, then peripherals, then latch
      next_p2_drive = quasi_port_two_latch;
      next_p2_alt   = `PIO_ZERO8;
      if (xdata_active) begin
         next_p2_drive = xdata_addr_hi[15:8];
         next_p2_alt   = ~`PIO_ZERO8;
      end else begin
         if (spi_en) begin
            next_p2_drive[`PIO_BIT_SCLK] = spi_master ? spi_sclk_out : 1'b1;
            next_p2_alt[`PIO_BIT_SCLK]   = spi_master;
            next_p2_drive[`PIO_BIT_MOSI] = spi_master ? spi_mosi_out : 1'b1;
            next_p2_alt[`PIO_BIT_MOSI]   = spi_master;
            next_p2_drive[`PIO_BIT_MISO] = spi_master ? 1'b1 : spi_miso_out;
            next_p2_alt[`PIO_BIT_MISO]   = ~spi_master;
            next_p2_drive[`PIO_BIT_SS]   = 1'b1;
         end
         if (modulator_en) begin
            next_p2_drive[`PIO_BIT_MODA] = modulator_output_a;
            next_p2_drive[`PIO_BIT_MODB] = modulator_output_b;
            next_p2_alt[`PIO_BIT_MODA]   = 1'b1;
            next_p2_alt[`PIO_BIT_MODB]   = 1'b1;
         end
      end
      // port three: alternate gated by latch bit
      next_p3_alt   = `PIO_ZERO8;
      next_p3_drive = ~`PIO_ZERO8;
      if (uart_en) begin
         next_p3_drive[`PIO_BIT_TXD] = uart_txd_out;
         next_p3_alt[`PIO_BIT_TXD]   = 1'b1;
         next_p3_drive[`PIO_BIT_RXD] = uart_rxd_oe ? uart_rxd_out : 1'b1;
         next_p3_alt[`PIO_BIT_RXD]   = uart_rxd_oe;
      end
      if (xdata_active) begin
         next_p3_drive[`PIO_BIT_WR] = xdata_wr_n;
         next_p3_drive[`PIO_BIT_RD] = xdata_rd_n;
         next_p3_alt[`PIO_BIT_WR]   = 1'b1;
         next_p3_alt[`PIO_BIT_RD]   = 1'b1;
      end
      next_p3_drive = next_p3_drive & quasi_port_three_latch;
      next_p3_alt   = next_p3_alt & quasi_port_three_latch;
      // register read: latch for rmw, pins otherwise
      case (sfr_addr)
         `PIO_ADDR_P1: next_rdata = sfr_rd_latch ? input_port_one_latch : p1_sample;
         `PIO_ADDR_P2: next_rdata = sfr_rd_latch ? quasi_port_two_latch : p2_sample;
         `PIO_ADDR_P3: next_rdata = sfr_rd_latch ? quasi_port_three_latch : p3_sample;
         default:      next_rdata = `PIO_ZERO8;
      endcase
   end

   always @(posedge core_clk) begin
      if (reset) begin
         sfr_rdata     <= `PIO_ZERO8;
         p1_analog_sel <= `PIO_LATCH_RESET;
         p2_pin_out    <= `PIO_ZERO8;
         p2_pin_oe     <= `PIO_ZERO8;
         p2_pullup_en  <= `PIO_LATCH_RESET;
         p3_pin_out    <= `PIO_ZERO8;
         p3_pin_oe     <= `PIO_ZERO8;
         p3_pullup_en  <= `PIO_LATCH_RESET;
      end else if (clk_en) begin
         if (sfr_rd) begin
            sfr_rdata <= next_rdata;
         end
         // port one has no output driver at all
         p1_analog_sel <= input_port_one_latch;
         // quasi pins drive only low unless a peripheral or external data access pushes
         p2_pin_out    <= next_p2_drive & next_p2_alt;
         p2_pin_oe     <= pio_low_oe(next_p2_drive, next_p2_alt);
         p2_pullup_en  <= next_p2_drive;
         p3_pin_out    <= next_p3_drive & next_p3_alt;
         p3_pin_oe     <= pio_low_oe(next_p3_drive, next_p3_alt);
         p3_pullup_en  <= next_p3_drive;
      end
   end

   // peripheral inputs from pin samples
   always @(posedge core_clk) begin
      if (reset) begin
         serial_periph_clock     <= 1'b1;
         spi_mosi_in             <= 1'b1;
         spi_miso_in             <= 1'b1;
         spi_ss_in               <= 1'b1;
         third_timer_clock_in    <= 1'b1;
         third_timer_ext_control <= 1'b1;
         modulator_alt_clock_in  <= 1'b1;
         uart_rxd_in             <= 1'b1;
         ext_interrupt_a         <= 1'b1;
         ext_interrupt_b         <= 1'b1;
         timer_a_count_in        <= 1'b1;
         timer_b_count_in        <= 1'b1;
      end else if (clk_en) begin
         serial_periph_clock     <= p2_pin_in[`PIO_BIT_SCLK];
         spi_mosi_in             <= p2_pin_in[`PIO_BIT_MOSI];
         spi_miso_in             <= p2_pin_in[`PIO_BIT_MISO];
         spi_ss_in               <= p2_pin_in[`PIO_BIT_SS];
         third_timer_clock_in    <= p2_pin_in[`PIO_BIT_SS];
         third_timer_ext_control <= p2_pin_in[`PIO_BIT_THIRD_TIMER_EXT_CONTROL];
         modulator_alt_clock_in  <= p2_pin_in[`PIO_BIT_MODCLK];
         uart_rxd_in             <= p3_pin_in[`PIO_BIT_RXD];
         ext_interrupt_a         <= p3_pin_in[`PIO_BIT_INTA];
         ext_interrupt_b         <= p3_pin_in[`PIO_BIT_INTB];
         timer_a_count_in        <= p3_pin_in[`PIO_BIT_TCA];
         timer_b_count_in        <= p3_pin_in[`PIO_BIT_TCB];
      end
   end

endmodule

// [dv/pio_ports_properties.sv]
// assertions on the port 1..3 block pins and reads
`timescale 1ns/100ps
module pio_ports_properties (
   // clock and reset
   input wire        core_clk,
   input wire        reset,
   // register access
   input wire [7:0]  sfr_addr,
   input wire        sfr_wr,
   input wire [1:0]  sfr_wr_op,
   input wire [7:0]  sfr_wdata,
   input wire        sfr_rd,
   input wire        sfr_rd_latch,
   input wire [7:0]  sfr_rdata,
   // pins
   input wire [7:0]  p1_analog_sel,
   input wire [7:0]  p2_pin_in,
   input wire [7:0]  p2_pin_out,
   input wire [7:0]  p2_pin_oe,
   input wire [7:0]  p2_pullup_en,
   input wire [7:0]  p3_pin_in,
   input wire [7:0]  p3_pin_out,
   input wire [7:0]  p3_pin_oe,
   // overrides and peripheral inputs
   input wire        xdata_active,
   input wire [15:0] xdata_addr_hi,
   input wire        spi_en,
   input wire        modulator_en,
   input wire        modulator_output_a,
   input wire        modulator_output_b,
   input wire        modulator_alt_clock_in,
   input wire        third_timer_ext_control
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   wire quiet = !xdata_active && !modulator_en && !spi_en;
   sequence s_wr(a);
      sfr_wr && sfr_addr == a && sfr_wr_op == 2'h0;
   endsequence
   a_p1_reset_analog: assert property ($fell(reset) |-> p1_analog_sel == 8'hff)
      else $error("port one not analog after reset");
   a_p1_write_sel: assert property (s_wr(8'h90) |-> ##2 p1_analog_sel == $past(sfr_wdata, 2))
      else $error("port one select does not follow write");
   a_p2_latch_drive: assert property (s_wr(8'ha0) ##1 quiet |-> ##1 p2_pin_oe == ~$past(sfr_wdata, 2)
      && p2_pullup_en == $past(sfr_wdata, 2) && p2_pin_out == 8'h00) else $error("port two drive wrong");
   a_xdata_addr_out: assert property (xdata_active ##1 $stable(xdata_addr_hi)
      |-> p2_pin_out == xdata_addr_hi[15:8] && p2_pin_oe == 8'hff) else $error("address byte not on port two");
   a_mod_pin_override: assert property (modulator_en && !xdata_active ##1 $stable(modulator_output_a)
      |-> p2_pin_out[6:5] == {modulator_output_b, modulator_output_a} && p2_pin_oe[6:5] == 2'b11)
      else $error("modulator not on port two");
   a_p3_zero_low: assert property (s_wr(8'hb0) |-> ##2 (~$past(sfr_wdata, 2) & ~(p3_pin_oe & ~p3_pin_out)) == 8'h00)
      else $error("port three zero bit not driven low");
   a_p3_pin_read: assert property (sfr_rd && !sfr_rd_latch && sfr_addr == 8'hb0 |=> sfr_rdata == $past(p3_pin_in, 2))
      else $error("port three pin read wrong");
   a_p2_alt_inputs: assert property (!$past(reset) && $stable(p2_pin_in)
      |-> modulator_alt_clock_in == p2_pin_in[7] && third_timer_ext_control == p2_pin_in[4])
      else $error("port two alternate input wrong");
endmodule
bind pio_ports pio_ports_properties u_props (.*);

// [dv/pio_pin_model.sv]
// outside devices and pull-ups resolving one quasi port
`timescale 1ns/100ps
module pio_pin_model (
   // block side
   input  wire [7:0] out,
   input  wire [7:0] oe,
   input  wire [7:0] pu,
   // outside device
   input  wire [7:0] ext_oe,
   input  wire [7:0] ext_v,
   output wire [7:0] lvl
);
   // strong drive wins, then the outside device, then the weak pull-up
   assign lvl = (oe & out) | (~oe & ext_oe & ext_v) | (~oe & ~ext_oe & pu);
endmodule

// [dv/pio_ports_tb.sv]
// self-checking bench for the port 1..3 block
`timescale 1ns/100ps
module pio_ports_tb;
   logic        core_clk, reset, clk_en, sfr_wr, sfr_rd, sfr_rd_latch, sfr_bit_val, xdata_active, xdata_wr_n, xdata_rd_n;
   logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, p1_pin_in, p1_analog_sel, p2_pin_in, p3_pin_in, ext_oe2, ext_oe3;
   logic [7:0]  p2_pin_out, p2_pin_oe, p2_pullup_en, p3_pin_out, p3_pin_oe, p3_pullup_en, ext_v2, ext_v3;
   logic [1:0]  sfr_wr_op;
   logic [2:0]  sfr_bit_sel;
   logic [15:0] xdata_addr_hi;
   logic        spi_en, spi_master, spi_sclk_out, spi_mosi_out, spi_miso_out, modulator_en, modulator_output_a;
   logic        modulator_output_b, uart_en, uart_txd_out, uart_rxd_out, uart_rxd_oe, serial_periph_clock, spi_mosi_in;
   logic        spi_miso_in, spi_ss_in, third_timer_clock_in, third_timer_ext_control, modulator_alt_clock_in;
   logic        uart_rxd_in, ext_interrupt_a, ext_interrupt_b, timer_a_count_in, timer_b_count_in;
   int          fail_count, n_tests;
   pio_ports dut (.*);
   pio_pin_model u_p2 (.out(p2_pin_out), .oe(p2_pin_oe), .pu(p2_pullup_en), .ext_oe(ext_oe2), .ext_v(ext_v2), .lvl(p2_pin_in));
   pio_pin_model u_p3 (.out(p3_pin_out), .oe(p3_pin_oe), .pu(p3_pullup_en), .ext_oe(ext_oe3), .ext_v(ext_v3), .lvl(p3_pin_in));
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk) #1;
   endtask
   // bit ops take the bit number from d[2:0] and the value from d[3]
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] op);
      {sfr_addr, sfr_wdata, sfr_wr_op, sfr_bit_sel, sfr_bit_val, sfr_wr} = {a, d, op, d[2:0], d[3], 1'b1};
      tick(1);
      sfr_wr = 1'b0;
      tick(2);
   endtask
   task automatic rd(input logic [7:0] a, input logic l, input string nm, input logic [7:0] exp);
      {sfr_addr, sfr_rd_latch, sfr_rd} = {a, l, 1'b1};
      tick(1);
      sfr_rd = 1'b0;
      chk(nm, sfr_rdata, exp);
      // let an edge pass so a following read never re-raises the strobe in this step
      tick(1);
   endtask
   task automatic t_port1;
      chk("p1 sel reset", p1_analog_sel, 8'hff);
      wr(8'h90, 8'h0f, 2'h0);
      chk("p1 sel", p1_analog_sel, 8'h0f);
      rd(8'h90, 1'b0, "p1 pins", 8'ha0);
   endtask
   task automatic t_port2;
      chk("p2 pullup reset", p2_pullup_en, 8'hff);
      wr(8'ha0, 8'hda, 2'h0);
      {ext_oe2, ext_v2} = {8'h88, 8'h00};
      tick(2);
      chk("p2 oe", p2_pin_oe, 8'h25);
      chk("p2 pullup", p2_pullup_en, 8'hda);
      chk("p2 alt in", {5'h0, modulator_alt_clock_in, third_timer_ext_control, spi_ss_in}, 8'h02);
      rd(8'ha0, 1'b0, "p2 pins", 8'h52);
      rd(8'ha0, 1'b1, "p2 latch", 8'hda);
      wr(8'ha0, 8'h08, 2'h1);
      rd(8'ha0, 1'b1, "p2 set bit", 8'hdb);
      wr(8'ha0, 8'h06, 2'h1);
      rd(8'ha0, 1'b1, "p2 clear bit", 8'h9b);
   endtask
   task automatic t_override;
      xdata_active = 1'b1;
      tick(3);
      chk("p2 address", p2_pin_out, 8'h3c);
      {xdata_active, modulator_en, modulator_output_a} = 3'h3;
      tick(3);
      chk("p2 modulator", {6'h0, p2_pin_out[6:5]}, 8'h01);
      modulator_en = 1'b0;
      rd(8'ha0, 1'b1, "p2 latch kept", 8'h9b);
   endtask
   task automatic t_port3;
      wr(8'hb0, 8'h0f, 2'h0);
      {spi_en, spi_master, spi_sclk_out, spi_mosi_out, spi_miso_out, uart_en} = 6'h3f;
      {uart_txd_out, uart_rxd_out, uart_rxd_oe, xdata_wr_n, xdata_rd_n, ext_oe3} = {5'h1f, 8'h04};
      tick(3);
      chk("p3 low", p3_pin_oe & ~p3_pin_out & 8'hf0, 8'hf0);
      rd(8'hb0, 1'b0, "p3 pins", 8'h0b);
      chk("p3 alt in", {5'h0, uart_rxd_in, ext_interrupt_b, ext_interrupt_a}, 8'h06);
      chk("p3 timer in", {6'h0, timer_b_count_in, timer_a_count_in}, 8'h00);
      chk("p3 pullup", p3_pullup_en, 8'h0f);
      chk("p2 spi out", p2_pin_out, 8'h03);
      chk("p2 spi in", {4'h0, serial_periph_clock, spi_mosi_in, spi_miso_in, third_timer_clock_in}, 8'h0e);
      rd(8'h91, 1'b1, "unmapped", 8'h00);
   endtask
   task automatic print_verdict;
      if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   initial begin
      #5000;
      fail_count++;
      print_verdict();
   end
   initial begin
      {clk_en, reset, sfr_wr, sfr_rd, sfr_rd_latch, sfr_bit_val, sfr_bit_sel, sfr_wr_op} = 11'h600;
      {sfr_addr, sfr_wdata, p1_pin_in, xdata_addr_hi, ext_oe2, ext_v2, ext_oe3, ext_v3} = {24'h0000a5, 16'h3c00, 32'h0};
      {xdata_active, xdata_wr_n, xdata_rd_n, spi_en, spi_master, spi_sclk_out, spi_mosi_out} = 7'h0;
      {spi_miso_out, modulator_en, modulator_output_a, modulator_output_b, uart_en, uart_txd_out} = 6'h0;
      {uart_rxd_out, uart_rxd_oe, fail_count, n_tests} = '0;
      repeat (4) @(posedge core_clk);
      #1 reset = 1'b0;
      tick(1);
      t_port1();
      t_port2();
      t_override();
      t_port3();
      print_verdict();
   end
endmodule
